// ---- rtl/ssc_map.svh ----
/*
  Constants of the serial shift counter unit: widths, reset values, limits.
  Assumes inclusion by the unit's package and its single design module.
*/
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// Widths
`define SSC_DATA_W 8
`define SSC_CNT_W 4

// Reset values
`define SSC_DATA_RST 8'h00
`define SSC_CNT_RST 4'h0

// Link clock ceilings, as divisors of the system clock
`define SSC_TW_DIV 16
`define SSC_3W_MST_DIV 2
`define SSC_3W_SLV_DIV 4

`endif

// ---- rtl/ssc_pkg.sv ----
/*
  Types of the serial shift counter unit.
  Assumes ssc_map.svh on the include path.
*/
`include "ssc_map.svh"

package ssc_pkg;

  // Wire mode
  typedef enum logic [1:0] {SSC_WM_OFF, SSC_WM_THREE, SSC_WM_TWO} ssc_wmode_t;

  // Shift clock source
  typedef enum logic [1:0] {SSC_CS_EXT, SSC_CS_TIMER, SSC_CS_SOFT} ssc_csrc_t;

  // Configuration word from software
  typedef struct packed {
    ssc_wmode_t wire_mode;
    ssc_csrc_t clk_src;
    logic clock_edge_select;
    logic hold_on_start;
    logic hold_on_ovf;
    logic clk_drive;
  } ssc_ctrl_t;

  // Status word to software
  typedef struct packed {
    logic [`SSC_DATA_W-1:0] shift_data;
    logic [`SSC_CNT_W-1:0] count;
    logic counter_overflow_flag;
    logic start_flag;
    logic wake;
  } ssc_stat_t;

endpackage

// ---- rtl/ssc_unit.sv ----
/*
  Serial shift counter unit: 8-bit shift register, 4-bit edge counter,
  three-wire and two-wire modes, start detection and clock stretching.
  Assumes a 250 MHz mclk, synchronous active-high srst, and pins resolved
  by the surrounding wiring from the output/enable pairs given here.
*/
`include "ssc_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// (RQ1) Processor-accessible 8-bit shift data register
// (RQ2) Software reads received byte before next shift
// (RQ3) MSB goes to pin chosen by mode
// (RQ4) Latch delays output to opposite edge
// (RQ5) Serial input always from data in pin
// (RQ6) Readable writable 4-bit counter with overflow
// (RQ7) Register and counter share one clock source
// (RQ8) External clock: count both edges
// (RQ9) Three sources: pin, timer, software strobe
// (RQ10) Two-wire start condition detected and flagged
// (RQ11) Two-wire hold clock low after start/overflow; code drives the held sck_o_r level, low only while it is 0
// (RQ12) Two-wire clock at most system over sixteen
// (RQ13) Three-wire: master half, slave quarter rate
// (RQ14) Wake from idle; two-wire from all
// (RQ15) Edge select swaps sample and shift edges
// (RQ16) Sixteen edges overflow: byte transfer done
// (RQ17) Master software toggles clock pin via strobe
// (RQ18) Wrap fifteen to zero, sticky overflow flag
module ssc_unit
  import ssc_pkg::*;
#(
  parameter int DATA_W = `SSC_DATA_W,
  parameter int CNT_W = `SSC_CNT_W
)
(
  // System clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Link clock from the serial clock pin
  input wire logic serial_clock_pin,
  // Serial data pin
  input wire logic serial_data_in,
  // Configuration and events from the processor
  input wire ssc_ctrl_t ctrl,
  input wire logic first_timer_ovf,
  input wire logic soft_shift_strobe,
  input wire logic clock_toggle_strobe,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdat,
  input wire logic cnt_wr,
  input wire logic [CNT_W-1:0] cnt_wdat,
  input wire logic ovf_clr,
  input wire logic start_clr,
  // Status to the processor
  output logic [DATA_W-1:0] shift_data_reg,
  output logic [CNT_W-1:0] count_r,
  output logic counter_overflow_flag,
  output logic start_flag,
  output logic wake_r,
  // Three-wire data out
  output logic data_out_r,
  // Two-wire data, open drain
  output logic sda_o_r,
  output logic sda_oe_n_r,
  // Clock pin drive
  output logic sck_o_r,
  output logic sck_oe_n_r
);

  // Elaboration check of the widths
  if (DATA_W < 2 || CNT_W < 2)
  begin : g_width_check
    $error("ssc_unit: DATA_W and CNT_W must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: capture the data pin on each edge of the clock pin

  logic rise_bit_r, rise_bit_nxt, fall_bit_r, fall_bit_nxt;

  // Next values for both edges; input is always the data pin
  always_comb
  begin
    rise_bit_nxt = serial_data_in; // RQ5
    fall_bit_nxt = serial_data_in; // RQ5
  end

  // Rising edge capture; stands until the next rising edge
  always_ff @(posedge serial_clock_pin)
  begin
    rise_bit_r <= rise_bit_nxt;
  end

  // Falling edge capture; stands until the next falling edge
  always_ff @(negedge serial_clock_pin)
  begin
    fall_bit_r <= fall_bit_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into mclk: pin levels through two flops, a third for edges
  // Clock pin level is synchronised, not a link-side toggle: link flops
  // see no reset, so a toggle would start and stay unknown

  logic [2:0] sda_s_r, sda_s_nxt, scl_s_r, scl_s_nxt;

  // Shift chains; stage 0 feeds only stage 1
  always_comb
  begin
    sda_s_nxt = {sda_s_r[1:0], serial_data_in};
    scl_s_nxt = {scl_s_r[1:0], serial_clock_pin};
  end

  // Synchroniser registers
  always_ff @(posedge mclk)
  begin
    sda_s_r <= sda_s_nxt;
    scl_s_r <= scl_s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection and event decode

  logic rise_ev, fall_ev, sample_ev, shift_ev, count_ev, sample_bit;
  logic start_ev, two_wire;

  // Edge roles by select: 0 samples rising, 1 samples falling
  function automatic logic edge_is_sample(input logic rising, input logic sel);
    edge_is_sample = rising ^ sel;
  endfunction

  // Events are only trusted with the pin rate under its ceiling
  always_comb
  begin
    rise_ev = scl_s_r[1] && !scl_s_r[2]; // RQ12 RQ13
    fall_ev = !scl_s_r[1] && scl_s_r[2];
    two_wire = (ctrl.wire_mode == SSC_WM_TWO);
    sample_ev = 1'b0;
    shift_ev = 1'b0;
    count_ev = 1'b0;
    sample_bit = sda_s_r[1];
    unique case (ctrl.clk_src) // RQ9
      SSC_CS_EXT:
      begin
        sample_ev = (rise_ev && edge_is_sample(1'b1, ctrl.clock_edge_select))
                 || (fall_ev && edge_is_sample(1'b0, ctrl.clock_edge_select)); // RQ15
        shift_ev = (rise_ev && !edge_is_sample(1'b1, ctrl.clock_edge_select))
                || (fall_ev && !edge_is_sample(1'b0, ctrl.clock_edge_select)); // RQ15
        sample_bit = ctrl.clock_edge_select ? fall_bit_r : rise_bit_r; // Settled
        count_ev = rise_ev || fall_ev; // RQ8
      end
      SSC_CS_TIMER:
      begin
        sample_ev = first_timer_ovf;
        shift_ev = first_timer_ovf;
        count_ev = first_timer_ovf; // RQ7
      end
      SSC_CS_SOFT:
      begin
        sample_ev = soft_shift_strobe;
        shift_ev = soft_shift_strobe;
        count_ev = soft_shift_strobe; // RQ7
      end
      default:
      begin
        sample_ev = 1'b0;
      end
    endcase
    if (ctrl.wire_mode == SSC_WM_OFF)
    begin
      sample_ev = 1'b0;
      shift_ev = 1'b0;
      count_ev = 1'b0;
    end
    // Data falls while clock is high
    start_ev = two_wire && scl_s_r[1] && sda_s_r[2] && !sda_s_r[1]; // RQ10
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register, counter, output latch, flags

  logic [DATA_W-1:0] shreg_r, shreg_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic latch_r, latch_nxt, ovf_r, ovf_nxt, start_r, start_nxt;
  logic wrap;

  always_comb
  begin
    shreg_nxt = shreg_r;
    cnt_nxt = cnt_r;
    latch_nxt = latch_r;
    wrap = count_ev && !cnt_wr && (cnt_r == {CNT_W{1'b1}});
    // Byte shifts in on the sample event; no receive buffer
    if (data_wr)
    begin
      shreg_nxt = data_wdat; // RQ1
    end
    else if (sample_ev)
    begin
      shreg_nxt = {shreg_r[DATA_W-2:0], sample_bit}; // RQ1 RQ2
    end
    // Counter shares the shift register's clock
    if (cnt_wr)
    begin
      cnt_nxt = cnt_wdat; // RQ6
    end
    else if (count_ev)
    begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // RQ7 RQ16 RQ18
    end
    // Latch opens on the opposite edge; internal sources keep it open
    if (ctrl.clk_src != SSC_CS_EXT || shift_ev)
    begin
      latch_nxt = shreg_r[DATA_W-1]; // RQ4
    end
    // Set wins over clear
    ovf_nxt = wrap || (ovf_r && !ovf_clr); // RQ18 RQ16
    start_nxt = start_ev || (start_r && !start_clr); // RQ10
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      shreg_r <= DATA_W'(`SSC_DATA_RST);
      cnt_r <= CNT_W'(`SSC_CNT_RST);
      latch_r <= 1'b0;
      ovf_r <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      shreg_r <= shreg_nxt;
      cnt_r <= cnt_nxt;
      latch_r <= latch_nxt;
      ovf_r <= ovf_nxt;
      start_r <= start_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and status outputs

  logic [DATA_W-1:0] sdo_nxt;
  logic [CNT_W-1:0] cnt_o_nxt;
  logic dout_nxt, sda_o_nxt, sda_oe_n_nxt, sck_o_nxt, sck_oe_n_nxt;
  logic hold, ovf_o_nxt, start_o_nxt, wake_nxt;

  always_comb
  begin
    sdo_nxt = shreg_nxt;
    cnt_o_nxt = cnt_nxt;
    ovf_o_nxt = ovf_nxt;
    start_o_nxt = start_nxt;
    // MSB through the latch to the pin of the mode
    dout_nxt = (ctrl.wire_mode == SSC_WM_THREE) ? latch_nxt : 1'b0; // RQ3
    sda_o_nxt = 1'b0;
    sda_oe_n_nxt = !(two_wire && !latch_nxt); // RQ3
    // Stretch the clock while a chosen flag stands
    hold = two_wire && ((start_nxt && ctrl.hold_on_start)
        || (ovf_nxt && ctrl.hold_on_ovf)); // RQ11
    // Software toggles its own clock level
    sck_o_nxt = clock_toggle_strobe ? ~sck_o_r : sck_o_r; // RQ17
    sck_oe_n_nxt = 1'b1;
    if (hold)
    begin
      sck_oe_n_nxt = 1'b0; // RQ11
    end
    else if (ctrl.clk_drive)
    begin
      sck_oe_n_nxt = two_wire && sck_o_nxt; // RQ17
    end
    if (hold)
    begin
      sck_o_nxt = sck_o_r;
    end
    // Overflow wakes from idle; two-wire start wakes from any sleep
    wake_nxt = ovf_nxt || (two_wire && start_nxt); // RQ14
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      shift_data_reg <= DATA_W'(`SSC_DATA_RST);
      count_r <= CNT_W'(`SSC_CNT_RST);
      counter_overflow_flag <= 1'b0;
      start_flag <= 1'b0;
      wake_r <= 1'b0;
      data_out_r <= 1'b0;
      sda_o_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      sck_o_r <= 1'b0;
      sck_oe_n_r <= 1'b1;
    end
    else
    begin
      shift_data_reg <= sdo_nxt;
      count_r <= cnt_o_nxt;
      counter_overflow_flag <= ovf_o_nxt;
      start_flag <= start_o_nxt;
      wake_r <= wake_nxt;
      data_out_r <= dout_nxt;
      sda_o_r <= sda_o_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      sck_o_r <= sck_o_nxt;
      sck_oe_n_r <= sck_oe_n_nxt;
    end
  end

endmodule

// ---- tb/ssc_asserts.sv ----
/*
  Port checker of the serial shift counter unit.
  Assumes binding into ssc_unit, one mclk domain.
*/
module ssc_asserts
  import ssc_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int CNT_W = 4
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Inputs
  input wire ssc_ctrl_t ctrl,
  input wire logic soft_shift_strobe,
  input wire logic first_timer_ovf,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdat,
  input wire logic cnt_wr,
  input wire logic [CNT_W-1:0] cnt_wdat,
  input wire logic ovf_clr,
  input wire logic start_clr,
  // Outputs
  input wire logic [DATA_W-1:0] shift_data_reg,
  input wire logic [CNT_W-1:0] count_r,
  input wire logic counter_overflow_flag,
  input wire logic start_flag,
  input wire logic sck_oe_n_r
);
  logic step;
  logic [DATA_W-1:0] sd_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Internal source event
  assign step = ctrl.wire_mode != SSC_WM_OFF &&
    ((ctrl.clk_src == SSC_CS_SOFT && soft_shift_strobe) ||
    (ctrl.clk_src == SSC_CS_TIMER && first_timer_ovf));
  // Last register value
  always_ff @(posedge mclk)
    sd_r <= shift_data_reg;
  ////////////////////////////////////////
  step_count_a: assert property (step && !cnt_wr |=> count_r == $past(count_r) + 1'b1)
    else $error("count did not step");
  step_shift_a: assert property (step && !data_wr |=> shift_data_reg[DATA_W-1:1] ==
    sd_r[DATA_W-2:0]) else $error("register did not shift");
  data_load_a: assert property (data_wr |=> shift_data_reg == $past(data_wdat))
    else $error("data write lost");
  count_load_a: assert property (cnt_wr |=> count_r == $past(cnt_wdat))
    else $error("count write lost");
  wrap_flag_a: assert property ((count_r == '1 && !cnt_wr) ##1 count_r == '0
    |-> counter_overflow_flag) else $error("wrap without flag");
  ovf_sticky_a: assert property (counter_overflow_flag && !ovf_clr |=>
    counter_overflow_flag) else $error("overflow flag dropped");
  start_sticky_a: assert property (start_flag && !start_clr |=> start_flag)
    else $error("start flag dropped");
  clock_hold_a: assert property ((ctrl.wire_mode == SSC_WM_TWO && ctrl.hold_on_start &&
    start_flag) [*2] |-> !sck_oe_n_r) else $error("clock not held");
  cover property (step);
  cover property (counter_overflow_flag);
  cover property (start_flag && !sck_oe_n_r);
endmodule

bind ssc_unit ssc_asserts #(.DATA_W(DATA_W), .CNT_W(CNT_W)) chk (
  .mclk(mclk), .srst(srst), .ctrl(ctrl), .soft_shift_strobe(soft_shift_strobe),
  .first_timer_ovf(first_timer_ovf), .data_wr(data_wr), .data_wdat(data_wdat),
  .cnt_wr(cnt_wr), .cnt_wdat(cnt_wdat), .ovf_clr(ovf_clr), .start_clr(start_clr),
  .shift_data_reg(shift_data_reg), .count_r(count_r),
  .counter_overflow_flag(counter_overflow_flag), .start_flag(start_flag),
  .sck_oe_n_r(sck_oe_n_r));

// ---- tb/ssc_partner.sv ----
/*
  Far-side serial master: clock and data towards the unit.
  Assumes the bench resolves the wires; clock idles low.
*/
module ssc_partner
(
  // Wire drive
  output logic sck,
  output logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    sdo = 1'b1;
  end
  // Data level set directly
  task put(input logic b);
    sdo = b;
  endtask
  // Byte MSB first, 48 ns bits
  task send(input logic [7:0] d, input logic ces);
    for (int i = 7; i >= 0; i--)
    begin
      if (!ces)
        sdo = d[i];
      #24 sck = 1'b1;
      if (ces)
        sdo = d[i];
      #24 sck = 1'b0;
    end
    #24 sdo = ~d[0]; // Line flips off the last bit
  endtask
  // Start: data falls while clock high
  task start_cond();
    sdo = 1'b1;
    sck = 1'b1;
    #48 sdo = 1'b0;
    #48 sck = 1'b0;
    #48 sck = 1'b1;
  endtask
endmodule

// ---- tb/tb_top.sv ----
/*
  Self-checking bench of the serial shift counter unit.
  Assumes ssc_partner as far side, ssc_asserts bound.
*/
module tb_top
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, srst = 1'b1, soft_shift_strobe = 1'b0, first_timer_ovf = 1'b0;
  logic data_wr = 1'b0, cnt_wr = 1'b0, ovf_clr = 1'b0, start_clr = 1'b0;
  logic clock_toggle_strobe = 1'b0;
  logic p_sck, p_sdo, sck_w, din, b, counter_overflow_flag, start_flag, wake_r;
  logic data_out_r, sda_o_r, sda_oe_n_r, sck_o_r, sck_oe_n_r;
  logic [7:0] data_wdat = 8'h00, shift_data_reg, b8;
  logic [3:0] cnt_wdat = 4'h0, count_r;
  ssc_ctrl_t ctrl = '0;
  integer seed = 32'h0504, n_mismatch = 0, tests_run = 0, m_data, m_cnt, m_ovf;
  // Clock and open-drain wires
  initial
    forever #2 mclk = ~mclk;
  assign sck_w = p_sck & (sck_oe_n_r | sck_o_r);
  assign din = p_sdo & sda_oe_n_r;
  ssc_unit DUT (.mclk(mclk), .srst(srst), .serial_clock_pin(sck_w), .serial_data_in(din),
    .ctrl(ctrl), .first_timer_ovf(first_timer_ovf), .soft_shift_strobe(soft_shift_strobe),
    .clock_toggle_strobe(clock_toggle_strobe), .data_wr(data_wr), .data_wdat(data_wdat),
    .cnt_wr(cnt_wr), .cnt_wdat(cnt_wdat), .ovf_clr(ovf_clr), .start_clr(start_clr),
    .shift_data_reg(shift_data_reg), .count_r(count_r),
    .counter_overflow_flag(counter_overflow_flag), .start_flag(start_flag), .wake_r(wake_r),
    .data_out_r(data_out_r), .sda_o_r(sda_o_r), .sda_oe_n_r(sda_oe_n_r), .sck_o_r(sck_o_r),
    .sck_oe_n_r(sck_oe_n_r));
  ssc_partner P (.sck(p_sck), .sdo(p_sdo));
  ////////////////////////////////////////
  // Compare tasks
  task chk(input logic [7:0] got, input int exp);
    tests_run++;
    if (got !== exp[7:0])
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, got, exp[7:0]);
    end
  endtask
  task chkf(input logic got, input int exp);
    chk({7'h0, got}, exp);
  endtask
  task test_done();
    $display("mismatches %0d compares %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait: 0 overflow, 1 start
  task wt(input int k);
    int i;
    for (i = 0; i < 60 && (k ? start_flag : counter_overflow_flag) !== 1'b1; i++)
      @(posedge mclk);
    if (i == 60)
    begin
      n_mismatch++;
      $display("ERROR %0t: wait ran out", $time);
      test_done();
    end
  endtask
  // Load register and counter, clear flags
  task load(input logic [7:0] d, input logic [3:0] c);
    @(posedge mclk);
    {data_wr, cnt_wr, ovf_clr, start_clr} <= 4'hf;
    data_wdat <= d;
    cnt_wdat <= c;
    @(posedge mclk);
    {data_wr, cnt_wr, ovf_clr, start_clr} <= 4'h0;
    m_data = d;
    m_cnt = c;
    m_ovf = 0;
    repeat (2) @(posedge mclk);
    chkf(counter_overflow_flag, 0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(shift_data_reg, 0);
    chk({count_r, counter_overflow_flag, wake_r, sda_oe_n_r, sck_oe_n_r}, 3);
    // Toggle strobe flips the clock level, twice back to idle
    for (int t = 1; t >= 0; t--)
    begin
      clock_toggle_strobe <= 1'b1;
      @(posedge mclk);
      clock_toggle_strobe <= 1'b0;
      repeat (2) @(posedge mclk);
      chkf(sck_o_r, t);
    end
    $display("reset test done");
    // Soft strobe, then timer from count 9
    ctrl.wire_mode <= SSC_WM_THREE;
    for (int s = 0; s < 2; s++)
    begin
      ctrl.clk_src <= s ? SSC_CS_TIMER : SSC_CS_SOFT;
      load(8'($random(seed)), s ? 4'h9 : 4'h0);
      for (int i = 0; i < 16; i++)
      begin
        b = 1'($random(seed));
        P.put(b);
        repeat (4) @(posedge mclk);
        soft_shift_strobe <= !s;
        first_timer_ovf <= s[0];
        @(posedge mclk);
        {soft_shift_strobe, first_timer_ovf} <= 2'b00;
        m_data = ((m_data << 1) | b) & 255;
        m_cnt = (m_cnt + 1) % 16;
        m_ovf = m_ovf | (m_cnt == 0);
        repeat (2) @(posedge mclk);
        chk(shift_data_reg, m_data);
        chk(count_r, m_cnt);
        chkf(data_out_r, m_data[7]);
      end
      chkf(counter_overflow_flag, m_ovf);
      chkf(wake_r, 1);
      $display("internal source test done");
    end
    // Pin clock, both edge selects
    ctrl.clk_src <= SSC_CS_EXT;
    for (int e = 0; e < 2; e++)
    begin
      ctrl.clock_edge_select <= e[0];
      load(8'($random(seed)), 4'h0);
      b8 = 8'($random(seed));
      #1.7;
      P.send(b8, e[0]);
      wt(0);
      repeat (8) @(posedge mclk);
      chk(shift_data_reg, b8);
      chk(count_r, 0);
      chkf(counter_overflow_flag, 1);
      $display("pin clock test done");
    end
    // Two-wire start and stretch
    ctrl <= '{SSC_WM_TWO, SSC_CS_EXT, 1'b0, 1'b1, 1'b0, 1'b0};
    load(8'hff, 4'h0);
    #1.7;
    P.start_cond();
    wt(1);
    repeat (4) @(posedge mclk);
    chkf(start_flag, 1);
    chkf(sck_w, 0);
    chkf(wake_r, 1);
    chk({sda_o_r, sda_oe_n_r}, 1);
    start_clr <= 1'b1;
    @(posedge mclk);
    start_clr <= 1'b0;
    repeat (6) @(posedge mclk);
    chkf(start_flag, 0);
    chkf(sck_w, 1);
    $display("two-wire test done");
    test_done();
  end
endmodule
